/* pkg/ufs_cfg.svh */
// Constants for the user flash sector store.
`ifndef UFS_CFG_SVH
`define UFS_CFG_SVH

`define UFS_ADDR_W     9
`define UFS_DATA_W     16
`define UFS_WORDS      512
`define UFS_SEC_BIT    8
`define UFS_SEC_LAST   8'hFF
`define UFS_CNT_ZERO   8'h00
`define UFS_CNT_ONE    8'h01
`define UFS_ADDR_ZERO  9'h000
`define UFS_ADDR_ONE   9'h001
`define UFS_ERASED     16'hFFFF
`define UFS_DATA_ZERO  16'h0000

`endif

/* pkg/ufs_pkg.sv */
// Types shared by the user flash sector store.
`default_nettype none
`include "ufs_cfg.svh"

package ufs_pkg;

  typedef enum logic [2:0] {
    UFS_IDLE   = 3'b000,
    UFS_RD     = 3'b001,
    UFS_RD_CAP = 3'b010,
    UFS_PG_RD  = 3'b011,
    UFS_PG_WR  = 3'b100,
    UFS_ERASE  = 3'b101
  } ufs_state_t;

  // Strobes from fabric logic; load_addr and the requests are one-cycle pulses, shift_en stays high for a whole word.
  typedef struct packed {
    logic shift_en;
    logic shift_bit;
    logic load_addr;
    logic read_req;
    logic prog_req;
    logic erase_req;
  } ufs_cmd_t;

  // Status presented back to fabric logic.
  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic                    ser_out;
    logic [`UFS_ADDR_W-1:0]  addr;
  } ufs_stat_t;

endpackage : ufs_pkg

`default_nettype wire

/* logic/ufs_mem.sv */
// Word array of the user flash sector store with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "ufs_cfg.svh"

module ufs_mem (
  input  wire logic                   core_clk,
  input  wire logic                   wr_en,
  input  wire logic [`UFS_ADDR_W-1:0] addr,
  input  wire logic [`UFS_DATA_W-1:0] wr_data,
  output logic      [`UFS_DATA_W-1:0] rd_data_q
);

  // Contents carry no reset: they model nonvolatile cells.
  logic [`UFS_DATA_W-1:0] cell_q [`UFS_WORDS];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      cell_q[addr] <= wr_data;
    end
    rd_data_q <= cell_q[addr];
  end

endmodule : ufs_mem

`default_nettype wire

/* logic/ufs_store.sv */
// Serial-access user flash sector store with auto-incrementing address.
`timescale 1ns/1ps
`default_nettype none
`include "ufs_cfg.svh"

module ufs_store (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              msb_first,
  input  wire ufs_pkg::ufs_cmd_t cmd,
  output var  ufs_pkg::ufs_stat_t stat
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ufs_pkg::ufs_state_t    state_q, state_d;
  logic [`UFS_ADDR_W-1:0] addr_q, addr_d;
  logic [`UFS_DATA_W-1:0] sh_q, sh_d;
  logic [7:0]             ers_cnt_q, ers_cnt_d;
  logic                   sector_q, sector_d;
  logic                   done_q, done_d;
  logic                   sout_q, sout_d;

  logic                   mem_we;
  logic [`UFS_ADDR_W-1:0] mem_addr;
  logic [`UFS_DATA_W-1:0] mem_wdata;
  logic [`UFS_DATA_W-1:0] mem_rdata;
  logic                   idle;

  assign idle = (state_q == ufs_pkg::UFS_IDLE);

  ufs_mem u_mem (
    .core_clk  (core_clk),
    .wr_en     (mem_we),
    .addr      (mem_addr),
    .wr_data   (mem_wdata),
    .rd_data_q (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    sh_d      = sh_q;
    ers_cnt_d = ers_cnt_q;
    sector_d  = sector_q;
    done_d    = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = addr_q;
    mem_wdata = `UFS_ERASED;
    case (state_q)
      ufs_pkg::UFS_IDLE: begin
        // Shifting is accepted only while idle so the word under work
        // cannot be disturbed.
        if (cmd.shift_en) begin
          if (msb_first) begin
            sh_d = {sh_q[`UFS_DATA_W-2:0], cmd.shift_bit};
          end else begin
            sh_d = {cmd.shift_bit, sh_q[`UFS_DATA_W-1:1]};
          end
        end
        if (cmd.load_addr) begin
          addr_d = sh_q[`UFS_ADDR_W-1:0];
        end
        if (cmd.erase_req) begin
          sector_d  = addr_q[`UFS_SEC_BIT];
          ers_cnt_d = `UFS_CNT_ZERO;
          state_d   = ufs_pkg::UFS_ERASE;
        end else if (cmd.prog_req) begin
          state_d = ufs_pkg::UFS_PG_RD;
        end else if (cmd.read_req) begin
          state_d = ufs_pkg::UFS_RD;
        end
      end
      ufs_pkg::UFS_RD: begin
        state_d = ufs_pkg::UFS_RD_CAP;
      end
      ufs_pkg::UFS_RD_CAP: begin
        // Reads pass straight through; nothing gates them.
        sh_d    = mem_rdata;
        addr_d  = addr_q + `UFS_ADDR_ONE;
        done_d  = 1'b1;
        state_d = ufs_pkg::UFS_IDLE;
      end
      ufs_pkg::UFS_PG_RD: begin
        state_d = ufs_pkg::UFS_PG_WR;
      end
      ufs_pkg::UFS_PG_WR: begin
        // Programming only clears bits, as a flash cell does; a word
        // that was not erased first keeps its old zeros.
        mem_we    = 1'b1;
        mem_wdata = mem_rdata & sh_q;
        addr_d    = addr_q + `UFS_ADDR_ONE;
        done_d    = 1'b1;
        state_d   = ufs_pkg::UFS_IDLE;
      end
      ufs_pkg::UFS_ERASE: begin
        // One word per cycle; the sector bit is fixed, so the other
        // sector is never written.
        mem_we    = 1'b1;
        mem_addr  = {sector_q, ers_cnt_q};
        mem_wdata = `UFS_ERASED;
        ers_cnt_d = ers_cnt_q + `UFS_CNT_ONE;
        if (ers_cnt_q == `UFS_SEC_LAST) begin
          done_d  = 1'b1;
          state_d = ufs_pkg::UFS_IDLE;
        end
      end
      default: begin
        state_d = ufs_pkg::UFS_IDLE;
      end
    endcase
    sout_d = msb_first ? sh_d[`UFS_DATA_W-1] : sh_d[0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q   <= ufs_pkg::UFS_IDLE;
      addr_q    <= `UFS_ADDR_ZERO;
      sh_q      <= `UFS_DATA_ZERO;
      ers_cnt_q <= `UFS_CNT_ZERO;
      sector_q  <= 1'b0;
      done_q    <= 1'b0;
      sout_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      sh_q      <= sh_d;
      ers_cnt_q <= ers_cnt_d;
      sector_q  <= sector_d;
      done_q    <= done_d;
      sout_q    <= sout_d;
    end
  end

  always_comb begin
    stat.busy    = !idle;
    stat.done    = done_q;
    stat.ser_out = sout_q;
    stat.addr    = addr_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence seq_erase_start;
    idle && cmd.erase_req;
  endsequence

  sequence seq_erase_first;
    state_q == ufs_pkg::UFS_ERASE && ers_cnt_q == `UFS_CNT_ZERO;
  endsequence

  chk_erase_begin: assert property (
    seq_erase_start |=> seq_erase_first ##1
      (state_q == ufs_pkg::UFS_ERASE && ers_cnt_q == `UFS_CNT_ONE))
    else $error("erase did not start at word zero");

  chk_erase_end: assert property (
    (state_q == ufs_pkg::UFS_ERASE && ers_cnt_q == `UFS_SEC_LAST)
      |=> idle && done_q ##1 !done_q)
    else $error("erase did not end after the last sector word");

  // A load in the erase cycle moves the address but not the sector, so
  // such cycles are left out here and covered by chk_sector_map.
  chk_sector_keep: assert property (
    (idle && cmd.erase_req && !cmd.load_addr) |=>
      (mem_addr[`UFS_SEC_BIT] ==
      $past(addr_q[`UFS_SEC_BIT])) [*8])
    else $error("erase wrote outside its sector");

  chk_addr_step: assert property (
    (state_q == ufs_pkg::UFS_RD_CAP || state_q == ufs_pkg::UFS_PG_WR)
      |=> addr_q == $past(addr_q) + `UFS_ADDR_ONE)
    else $error("address did not step after a word access");

  chk_addr_load: assert property (
    (idle && cmd.load_addr && !cmd.shift_en)
      |=> addr_q == $past(sh_q[`UFS_ADDR_W-1:0]))
    else $error("address load lost");

  chk_prog_clear: assert property (
    (state_q == ufs_pkg::UFS_PG_WR) |->
      mem_we && (mem_wdata & ~mem_rdata) == `UFS_DATA_ZERO
      && mem_addr == addr_q && mem_rdata == u_mem.cell_q[addr_q])
    else $error("program set a bit or hit the wrong word");

  chk_read_path: assert property (
    (idle && cmd.read_req && !cmd.erase_req && !cmd.prog_req)
      |=> ##1 state_q == ufs_pkg::UFS_RD_CAP ##1
      (sh_q == $past(mem_rdata) && done_q))
    else $error("read data not delivered in three cycles");

  chk_busy_start: assert property (
    (idle && (cmd.read_req || cmd.prog_req || cmd.erase_req))
      |=> stat.busy)
    else $error("request did not make the store busy");

  chk_sector_map: assert property (
    seq_erase_start |=> sector_q == $past(addr_q[`UFS_SEC_BIT]))
    else $error("sector not taken from the address top bit");

  chk_shift_order: assert property (
    (idle && cmd.shift_en && msb_first && !cmd.read_req)
      |=> sh_q[0] == $past(cmd.shift_bit))
    else $error("msb-first shift put the bit in the wrong place");

  chk_shift_lsb: assert property (
    (idle && cmd.shift_en && !msb_first)
      |=> sh_q[`UFS_DATA_W-1] == $past(cmd.shift_bit))
    else $error("lsb-first shift put the bit in the wrong place");

endmodule : ufs_store

`default_nettype wire

/* verif/ufs_fab.sv */
// Fabric-side user logic model that drives the store's strobes.
`timescale 1ns/1ps
`default_nettype none
module ufs_fab (
  input  wire logic               core_clk,
  input  wire ufs_pkg::ufs_stat_t stat,
  output var  ufs_pkg::ufs_cmd_t  cmd
);
  initial cmd = '0;
  // Inputs move on the falling edge, half a cycle clear of sampling.
  task automatic put_word(input logic msb, input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      cmd.shift_en  = 1'b1;
      cmd.shift_bit = msb ? w[15-i] : w[i];
    end
    @(negedge core_clk);
    cmd.shift_en  = 1'b0;
    cmd.shift_bit = ~cmd.shift_bit;
  endtask : put_word
  // Kind 0 loads the address, 1 reads, 2 programs, 3 erases a sector.
  task automatic strobe(input int k, output logic ok, output logic bsy);
    @(negedge core_clk);
    cmd.load_addr = (k == 0);
    cmd.read_req  = (k == 1);
    cmd.prog_req  = (k == 2);
    cmd.erase_req = (k == 3);
    @(negedge core_clk);
    cmd[3:0] = 4'h0;
    bsy = stat.busy;
    ok = (k == 0);
    for (int n = 0; n < 300 && ok !== 1'b1; n++) begin
      ok = stat.done;
      if (ok !== 1'b1) @(negedge core_clk);
    end
  endtask : strobe
  task automatic get_word(input logic msb, output logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      if (msb) w[15-i] = stat.ser_out; else w[i] = stat.ser_out;
      cmd.shift_en = 1'b1;
      @(negedge core_clk);
    end
    cmd.shift_en = 1'b0;
  endtask : get_word
endmodule : ufs_fab
`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench for the user flash sector store.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               core_clk;
  logic               rst;
  logic               msb_first;
  logic               ok;
  logic               bsy;
  logic [15:0]        w;
  logic [15:0]        mem_exp [512];
  int                 num_errors;
  int                 num_checks;
  ufs_pkg::ufs_cmd_t  cmd;
  ufs_pkg::ufs_stat_t stat;

  ufs_store u_dut (.core_clk(core_clk), .rst(rst), .msb_first(msb_first),
                   .cmd(cmd), .stat(stat));
  ufs_fab u_fab (.core_clk(core_clk), .stat(stat), .cmd(cmd));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // Flash cells only clear bits, so a program leaves old AND new.
  function automatic logic [15:0] prog_result(input logic [15:0] old, d);
    return old & d;
  endfunction : prog_result

  function automatic logic [15:0] next_addr(input logic [8:0] a);
    return {7'h00, a + 9'h001};
  endfunction : next_addr

  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic set_addr(input logic [8:0] a);
    u_fab.put_word(msb_first, {7'h00, a});
    u_fab.strobe(0, ok, bsy);
    check("load busy", 16'h0000, {15'h0000, bsy});
    check("addr", {7'h00, a}, {7'h00, stat.addr});
  endtask : set_addr

  // Random low bits show that only the top bit picks the sector.
  task automatic erase(input logic sec);
    logic [8:0] a;
    a = {sec, 8'($urandom)};
    set_addr(a);
    u_fab.strobe(3, ok, bsy);
    check("erase busy", 16'h0001, {15'h0000, bsy});
    check("erase done", 16'h0001, {15'h0000, ok});
    check("erase addr", {7'h00, a}, {7'h00, stat.addr});
    for (int i = 0; i < 256; i++) mem_exp[{sec, 8'(i)}] = 16'hFFFF;
  endtask : erase

  // The user side keeps the erase-first rule: a word that is not known
  // to be erased has its whole sector erased before it is programmed.
  task automatic prog(input logic [8:0] a, input logic [15:0] d);
    if (mem_exp[a] !== 16'hFFFF) erase(a[8]);
    set_addr(a);
    u_fab.put_word(msb_first, d);
    u_fab.strobe(2, ok, bsy);
    mem_exp[a] = prog_result(mem_exp[a], d);
    check("prog busy", 16'h0001, {15'h0000, bsy});
    check("prog done", 16'h0001, {15'h0000, ok});
    check("prog addr", next_addr(a), {7'h00, stat.addr});
  endtask : prog

  task automatic rd(input logic [8:0] a);
    u_fab.strobe(1, ok, bsy);
    check("read busy", 16'h0001, {15'h0000, bsy});
    check("read done", 16'h0001, {15'h0000, ok});
    u_fab.get_word(msb_first, w);
    check("read data", mem_exp[a], w);
    check("read addr", next_addr(a), {7'h00, stat.addr});
  endtask : rd

  initial begin
    logic [8:0] a;
    rst = 1'b1;
    msb_first = 1'b1;
    void'($urandom(27150));
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    check("reset addr", 16'h0000, {7'h00, stat.addr});
    check("reset busy", 16'h0000, {15'h0000, stat.busy});
    erase(1'b0);
    erase(1'b1);
    for (int i = 0; i < 24; i++) begin
      a = (i < 4) ? {i[0], {8{i[1]}}} : 9'($urandom);
      msb_first = 1'($urandom);
      prog(a, 16'($urandom));
      if (i[0]) prog(a, 16'($urandom));
      prog(a + 9'h001, 16'($urandom));
      set_addr(a);
      rd(a);
      rd(a + 9'h001);
    end
    erase(1'b1);
    for (int i = 0; i < 4; i++) begin
      a = {i[0], {8{i[1]}}};
      set_addr(a);
      rd(a);
    end
    give_verdict();
  end

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
